// ===== rtl/hcap_pkg.sv
// Constants and types shared by the harvard core ALU pipeline
package hcap_pkg;
  localparam int          DATA_W       = 8;              // Data word and accumulator width
  localparam int          INSTR_W      = 12;             // Instruction word width
  localparam int          PC_MAX_W     = 11;             // Widest program counter (2048 words)
  localparam int          PC_SMALL_W   = 9;              // Program counter for 512 words
  localparam int          FILE_ADDR_W  = 5;              // Data file address width
  localparam int          FILE_DEPTH   = 32;             // Data file entries, one bank
  // Fixed places of the special regs in the data map
  localparam logic [4:0]  ADDR_INDIRECT = 5'h00;         // Reads through the pointer
  localparam logic [4:0]  ADDR_PCL      = 5'h02;         // Low byte of the program counter
  localparam logic [4:0]  ADDR_STATUS   = 5'h03;         // Flags and page select
  localparam logic [4:0]  ADDR_FSR      = 5'h04;         // Indirect pointer
  // Bit positions inside the status special_reg
  localparam int          BIT_CARRY    = 0;              // Carry, inverted borrow when subtracting
  localparam int          BIT_NIBBLE   = 1;              // nibble_out_bit
  localparam int          BIT_ZERO     = 2;              // Zero result
  localparam int          BIT_PAGE_LO  = 5;              // Page select, low bit
  localparam int          BIT_PAGE_HI  = 6;              // Page select, high bit
  localparam logic [7:0]  STATUS_RST   = 8'h18;          // Status after reset
  localparam logic [11:0] INSTR_NOP    = 12'h000;        // Pipeline filler
  // Four oscillator clocks make one instruction cycle
  typedef enum logic [1:0]
  {
    HCAP_Q1 = 2'b00,
    HCAP_Q2 = 2'b01,
    HCAP_Q3 = 2'b10,
    HCAP_Q4 = 2'b11
  } hcap_phase_t;
endpackage : hcap_pkg

// ===== rtl/hcap_core.sv
// Harvard core: two-stage pipeline, 8-bit ALU, accumulator and data file
`timescale 1ns/1ps
`default_nettype none

// What this block does
// [RQ1] Program fetch uses its own bus, independent of data file accesses.
// [RQ2] Instructions are single 12-bit words, fetched in one instruction cycle.
// [RQ3] Next instruction is fetched while the current one executes.
// [RQ4] All instructions finish in one instruction cycle unless flow changes.
// [RQ5] Flow-changing instructions take two instruction cycles.
// [RQ6] On a taken branch the prefetched word is discarded, target fetched instead.
// [RQ7] Program space is 512 or 2048 twelve-bit words, all internal.
// [RQ8] Program counter and special regs sit in data map, direct or indirect.
// [RQ9] 8-bit ALU does add, subtract, shift and logic operations.
// [RQ10] Arithmetic is two's complement unless stated otherwise.
// [RQ11] Two-operand ops use accumulator plus a file register or literal.
// [RQ12] Single-operand ops work on accumulator or a file register.
// [RQ13] Accumulator is 8 bits, feeds the ALU, has no data address.
// [RQ14] ALU updates carry, nibble and zero flags per instruction.
// [RQ15] Subtraction uses carry as borrow and nibble bit as low-nibble borrow.
// [RQ16] Zero flag set when 8-bit result is zero, else cleared.
// [RQ17] In RC mode the second oscillator pin outputs quarter-rate cycle clock.
// [RQ18] Active-low external reset holds the core in reset while low.
module hcap_core
  import hcap_pkg::*;
#(
  parameter int PC_W = hcap_pkg::PC_SMALL_W                   // 9 for 512 words, 11 for 2048
)
(
  input  wire logic                          i_clk_sys,        // 100 MHz core clock
  input  wire logic                          i_resetn,         // Synchronous system reset
  input  wire logic                          i_master_reset_n, // External reset pin
  input  wire logic                          i_rc_mode,        // Oscillator strap: RC mode
  input  wire logic                          i_pmem_we,        // Program memory load strobe
  input  wire logic [PC_W-1:0]               i_pmem_waddr,     // Program memory load address
  input  wire logic [hcap_pkg::INSTR_W-1:0]  i_pmem_wdata,     // Program memory load word
  output logic      [PC_W-1:0]               o_prog_addr,      // Program bus fetch address
  output logic      [hcap_pkg::INSTR_W-1:0]  o_instr,          // Instruction register
  output logic      [hcap_pkg::DATA_W-1:0]   o_w_reg,          // Accumulator
  output logic      [hcap_pkg::DATA_W-1:0]   o_status,         // Status special_reg
  output logic                               o_xtal_out_pin,   // cycle_clock_out in RC mode
  output logic                               o_core_reset      // Core held in reset
);
  import hcap_pkg::*;

  localparam logic [PC_MAX_W-1:0] PC_MASK   = PC_MAX_W'((1 << PC_W) - 1);
  localparam logic [PC_MAX_W-1:0] RESET_VEC = PC_MASK;   // Last word of program space

  typedef struct packed {
    logic                                   mrst1;   // Reset pin, first stage
    logic                                   mrst2;   // Reset pin, second stage
    logic                                   rc1;     // RC strap, first stage
    logic                                   rc2;     // RC strap, second stage
    hcap_phase_t                            q;       // Oscillator phase in the cycle
    logic [PC_MAX_W-1:0]                    pc;      // Address being fetched
    logic [INSTR_W-1:0]                     ir;      // Word being executed
    logic                                   flush;   // Current ir is discarded
    logic [DATA_W-1:0]                      w;       // Accumulator, not in the map
    logic [PC_MAX_W-1:0]                    stk0;    // Return stack top
    logic [PC_MAX_W-1:0]                    stk1;    // Return stack bottom
    logic [FILE_DEPTH-1:0][DATA_W-1:0]      file;    // Data file incl. special regs
    logic                                   cycle_clock_out;  // Quarter-rate cycle clock
    logic                                   core_hold; // Core held, kept in a flop for the pin
  } hcap_state_t;

  hcap_state_t             st_r;
  hcap_state_t             st_nxt;
  logic [INSTR_W-1:0]      pmem [1 << PC_W];         // Internal program memory
  logic [INSTR_W-1:0]      fetch_word;
  logic                    run;
  logic                    commit;
  logic [FILE_ADDR_W-1:0]  fa;
  logic [DATA_W-1:0]       fval;
  logic [DATA_W-1:0]       lit;
  logic [DATA_W-1:0]       res;
  logic [DATA_W:0]         sum9;
  logic [4:0]              sum5;
  logic                    alu_op;
  logic                    wr_w;
  logic                    wr_f;
  logic                    upd_z;
  logic                    upd_c;
  logic                    upd_dc;
  logic                    c_new;
  logic                    dc_new;
  logic                    branch;
  logic                    skip;
  logic                    push;
  logic                    pop;
  logic [PC_MAX_W-1:0]     target;
  logic [1:0]              page;

  // Program memory loads; fetches read it on their own bus [RQ1] [RQ7]
  always_ff @(posedge i_clk_sys)
  begin
    if (i_pmem_we)
    begin
      pmem[i_pmem_waddr] <= i_pmem_wdata;
    end
  end

  assign fetch_word = pmem[st_r.pc[PC_W-1:0]];          // Whole word in one cycle [RQ2]
  assign run        = st_r.mrst2;                      // Pin released [RQ18]
  assign commit     = run && (st_r.q == HCAP_Q4);
  assign page       = st_r.file[ADDR_STATUS][BIT_PAGE_HI:BIT_PAGE_LO];

  // Operand fetch: indirect access goes through the pointer [RQ8]
  always_comb
  begin
    fa = (st_r.ir[4:0] == ADDR_INDIRECT) ? st_r.file[ADDR_FSR][4:0] : st_r.ir[4:0];
    if (fa == ADDR_INDIRECT)
      fval = 8'h00;                                    // Pointer to itself reads zero
    else if (fa == ADDR_PCL)
      fval = st_r.pc[DATA_W-1:0];                      // Counter visible in data map [RQ8]
    else
      fval = st_r.file[fa];
    lit = st_r.ir[DATA_W-1:0];
  end

  // Decode and ALU; literal or file operand against the accumulator [RQ9] [RQ11] [RQ12]
  always_comb
  begin
    res    = 8'h00;
    sum9   = 9'h000;
    sum5   = 5'h00;
    alu_op = 1'b0;
    wr_w   = 1'b0;
    wr_f   = 1'b0;
    upd_z  = 1'b0;
    upd_c  = 1'b0;
    upd_dc = 1'b0;
    c_new  = st_r.file[ADDR_STATUS][BIT_CARRY];
    dc_new = st_r.file[ADDR_STATUS][BIT_NIBBLE];
    branch = 1'b0;
    skip   = 1'b0;
    push   = 1'b0;
    pop    = 1'b0;
    target = st_r.pc;
    unique casez (st_r.ir[11:6])
      6'b000000: begin res = st_r.w; wr_f = st_r.ir[5]; end   // Store or no-op group
      6'b000001: begin res = 8'h00; alu_op = 1'b1; upd_z = 1'b1; end
      6'b000010:
      begin
        // Subtract as add of complement; carry reads as not-borrow [RQ10] [RQ15]
        sum9 = {1'b0, fval} + {1'b0, ~st_r.w} + 9'h001;
        sum5 = {1'b0, fval[3:0]} + {1'b0, ~st_r.w[3:0]} + 5'h01;
        res = sum9[7:0]; c_new = sum9[8]; dc_new = sum5[4];
        alu_op = 1'b1; upd_z = 1'b1; upd_c = 1'b1; upd_dc = 1'b1;
      end
      6'b000011: begin res = fval - 8'h01; alu_op = 1'b1; upd_z = 1'b1; end
      6'b000100: begin res = st_r.w | fval; alu_op = 1'b1; upd_z = 1'b1; end
      6'b000101: begin res = st_r.w & fval; alu_op = 1'b1; upd_z = 1'b1; end
      6'b000110: begin res = st_r.w ^ fval; alu_op = 1'b1; upd_z = 1'b1; end
      6'b000111:
      begin
        sum9 = {1'b0, fval} + {1'b0, st_r.w};
        sum5 = {1'b0, fval[3:0]} + {1'b0, st_r.w[3:0]};
        res = sum9[7:0]; c_new = sum9[8]; dc_new = sum5[4];
        alu_op = 1'b1; upd_z = 1'b1; upd_c = 1'b1; upd_dc = 1'b1;
      end
      6'b001000: begin res = fval; alu_op = 1'b1; upd_z = 1'b1; end
      6'b001001: begin res = ~fval; alu_op = 1'b1; upd_z = 1'b1; end
      6'b001010: begin res = fval + 8'h01; alu_op = 1'b1; upd_z = 1'b1; end
      6'b001011: begin res = fval - 8'h01; alu_op = 1'b1; skip = (res == 8'h00); end
      6'b001100:
      begin
        res = {st_r.file[ADDR_STATUS][BIT_CARRY], fval[7:1]};
        c_new = fval[0]; alu_op = 1'b1; upd_c = 1'b1;
      end
      6'b001101:
      begin
        res = {fval[6:0], st_r.file[ADDR_STATUS][BIT_CARRY]};
        c_new = fval[7]; alu_op = 1'b1; upd_c = 1'b1;
      end
      6'b001110: begin res = {fval[3:0], fval[7:4]}; alu_op = 1'b1; end
      6'b001111: begin res = fval + 8'h01; alu_op = 1'b1; skip = (res == 8'h00); end
      6'b0100??: begin res = fval & ~(8'h01 << st_r.ir[7:5]); wr_f = 1'b1; end
      6'b0101??: begin res = fval | (8'h01 << st_r.ir[7:5]); wr_f = 1'b1; end
      6'b0110??: skip = ~fval[st_r.ir[7:5]];
      6'b0111??: skip = fval[st_r.ir[7:5]];
      6'b1000??: begin res = lit; wr_w = 1'b1; branch = 1'b1; pop = 1'b1;
                       target = st_r.stk0; end
      6'b1001??: begin branch = 1'b1; push = 1'b1; target = {page, 1'b0, lit}; end
      6'b101???: begin branch = 1'b1; target = {page, st_r.ir[8:0]}; end
      6'b1100??: begin res = lit; wr_w = 1'b1; end
      6'b1101??: begin res = st_r.w | lit; wr_w = 1'b1; upd_z = 1'b1; end
      6'b1110??: begin res = st_r.w & lit; wr_w = 1'b1; upd_z = 1'b1; end
      6'b1111??: begin res = st_r.w ^ lit; wr_w = 1'b1; upd_z = 1'b1; end
    endcase
    // Destination bit picks accumulator or file register [RQ12]
    if (alu_op)
    begin
      wr_w = ~st_r.ir[5];
      wr_f = st_r.ir[5];
    end
    // A write to the counter low byte is a computed jump [RQ8]
    if (wr_f && (fa == ADDR_PCL))
    begin
      branch = 1'b1;
      target = {page, 1'b0, res};
    end
  end

  // Next state: phase counter, execute at end of cycle, prefetch alongside
  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.mrst1 = i_master_reset_n;
    st_nxt.mrst2 = st_r.mrst1;
    st_nxt.rc1   = i_rc_mode;
    st_nxt.rc2   = st_r.rc1;
    st_nxt.core_hold = ~st_r.mrst1;                    // Tracks ~mrst2 so the pin is a flop [RQ18]
    unique case (st_r.q)
      HCAP_Q1: st_nxt.q = HCAP_Q2;
      HCAP_Q2: st_nxt.q = HCAP_Q3;
      HCAP_Q3: st_nxt.q = HCAP_Q4;
      HCAP_Q4: st_nxt.q = HCAP_Q1;
    endcase
    if (commit)
    begin
      // Discarded words still advance the fetch, so a branch costs one cycle [RQ6]
      if (!st_r.flush)
      begin
        if (wr_w)
          st_nxt.w = res;                              // [RQ13]
        if (wr_f && (fa != ADDR_INDIRECT) && (fa != ADDR_PCL))
          st_nxt.file[fa] = res;
        // Flags land after the data write so they win on a status target [RQ14]
        if (upd_z)
          st_nxt.file[ADDR_STATUS][BIT_ZERO] = (res == 8'h00);        // [RQ16]
        if (upd_c)
          st_nxt.file[ADDR_STATUS][BIT_CARRY] = c_new;
        if (upd_dc)
          st_nxt.file[ADDR_STATUS][BIT_NIBBLE] = dc_new;
        if (push)
        begin
          st_nxt.stk1 = st_r.stk0;
          st_nxt.stk0 = st_r.pc;                       // pc already names return word
        end
        if (pop)
          st_nxt.stk0 = st_r.stk1;
      end
      // Fetch overlaps execute; flow change fetches target in the extra cycle [RQ3] [RQ5]
      st_nxt.ir    = fetch_word;
      st_nxt.flush = !st_r.flush && (branch || skip);  // [RQ6]
      if (!st_r.flush && branch)
        st_nxt.pc = target & PC_MASK;
      else
        st_nxt.pc = PC_MAX_W'(st_r.pc + 1'b1) & PC_MASK;   // [RQ4]
    end
    // Pin low holds the core at the reset vector; syncs keep running [RQ18]
    if (!st_r.mrst2)
    begin
      st_nxt.q                   = HCAP_Q1;
      st_nxt.pc                  = RESET_VEC;
      st_nxt.ir                  = INSTR_NOP;
      st_nxt.flush               = 1'b0;
      st_nxt.file[ADDR_STATUS]   = STATUS_RST;
      st_nxt.file[ADDR_FSR]      = 8'h00;
    end
    // Cycle clock low in the first half, high in the second [RQ17]
    st_nxt.cycle_clock_out = st_r.rc2 && ((st_nxt.q == HCAP_Q3) || (st_nxt.q == HCAP_Q4));
  end

  // State register; reset forces constants only
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      st_r                    <= '0;
      st_r.pc                 <= RESET_VEC;
      st_r.file[ADDR_STATUS]  <= STATUS_RST;
      st_r.core_hold          <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign o_prog_addr    = st_r.pc[PC_W-1:0];
  assign o_instr        = st_r.ir;
  assign o_w_reg        = st_r.w;
  assign o_status       = st_r.file[ADDR_STATUS];
  assign o_xtal_out_pin = st_r.cycle_clock_out;
  assign o_core_reset   = st_r.core_hold;

  // Checks next to the logic they guard
  a_prefetch_word: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RQ3]
    commit && run |=> (st_r.ir == $past(fetch_word)) || !st_r.mrst2)
    else $error("prefetched word not loaded into instruction register");

  a_single_cycle: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RQ4]
    commit && !st_r.flush && !branch |=> !st_r.mrst2 ||
      (st_r.pc == (PC_MAX_W'($past(st_r.pc) + 1'b1) & PC_MASK)))
    else $error("non-branch did not advance fetch by one word");

  a_branch_flush: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RQ6]
    commit && !st_r.flush && branch && st_r.mrst1 |=> st_r.flush && st_r.pc == ($past(target) & PC_MASK))
    else $error("taken branch did not discard prefetch");

  a_two_cycles: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RQ5]
    commit && st_r.flush ##1 run [*3] |=> !st_r.flush)
    else $error("branch bubble lasted more than one cycle");

  a_zero_flag: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RQ16]
    commit && !st_r.flush && upd_z && st_r.mrst1 |=> o_status[BIT_ZERO] == ($past(res) == 8'h00))
    else $error("zero flag does not match result");

  a_sub_borrow: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RQ15]
    commit && !st_r.flush && st_r.ir[11:6] == 6'b000010 && st_r.mrst1
      |=> o_status[BIT_CARRY] == ($past(fval) >= $past(st_r.w)))
    else $error("carry is not the inverted borrow");

  a_add_result: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RQ10]
    commit && !st_r.flush && st_r.ir[11:5] == 7'b0001110 && st_r.mrst1
      |=> o_w_reg == DATA_W'($past(st_r.w) + $past(fval)))
    else $error("add result wrong");

  a_literal_load: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RQ11]
    commit && !st_r.flush && st_r.ir[11:8] == 4'b1100 && st_r.mrst1 |=> o_w_reg == $past(lit))
    else $error("literal not loaded into accumulator");

  a_reset_hold: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RQ18]
    !st_r.mrst2 |=> st_r.pc == RESET_VEC && st_r.q == HCAP_Q1 && st_r.ir == INSTR_NOP &&
      (o_core_reset != $past(st_r.mrst1)))
    else $error("core not held while reset pin low");

  a_cycle_clock: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // [RQ17]
    $rose(o_xtal_out_pin) ##1 (run && st_r.rc2) [*4] |-> $rose(o_xtal_out_pin))
    else $error("cycle clock not a quarter of the input rate");
endmodule : hcap_core

`default_nettype wire

// ===== dv/hcap_pmem_loader.sv
// Program memory loader model standing in for the program source
`timescale 1ns/1ps
`default_nettype none
module hcap_pmem_loader
#(
  parameter int PC_W = 9                                       // Program counter width
)
(
  input  wire logic                          i_clk_sys,        // Core clock
  input  wire logic                          i_start,          // Begin loading
  output logic                               o_pmem_we,        // Word write strobe
  output logic      [PC_W-1:0]               o_pmem_waddr,     // Word address
  output logic      [hcap_pkg::INSTR_W-1:0]  o_pmem_wdata,     // Word data
  output logic                               o_done            // All words stored
);
  import hcap_pkg::*;
  localparam int N = 20;
  // Test program, one 12-bit word per entry; last entry lands on the reset vector
  // Zero fillers after the return and the looping jump keep the discarded prefetch a known word
  localparam logic [INSTR_W-1:0] PROG [N] = '{12'h0C0F, 12'h0030, 12'h0C01, 12'h01D0,
    12'h0090, 12'h0FFF, 12'h0A09, 12'h0C55, 12'h0C66, 12'h0C77, 12'h0031, 12'h0C11,
    12'h0024, 12'h0200, 12'h0911, 12'h0A0F, 12'h0000, 12'h08AB, 12'h0000,
    12'h0000};
  // Back-to-back single-word writes; address bus released to inverted value after
  initial
  begin
    o_pmem_we    = 1'b0;
    o_pmem_waddr = '0;
    o_pmem_wdata = '0;
    o_done       = 1'b0;
    wait (i_start === 1'b1);
    for (int i = 0; i < N; i++)
    begin
      @(posedge i_clk_sys);
      o_pmem_we    <= 1'b1;
      o_pmem_waddr <= (i == N - 1) ? '1 : PC_W'(i);
      o_pmem_wdata <= PROG[i];
    end
    @(posedge i_clk_sys);
    o_pmem_we    <= 1'b0;
    o_pmem_waddr <= ~o_pmem_waddr;
    o_pmem_wdata <= ~o_pmem_wdata;
    o_done       <= 1'b1;
  end
endmodule : hcap_pmem_loader
`default_nettype wire

// ===== dv/test_harvard_core_alu_pipeline.sv
// Self-checking testbench for the harvard core ALU pipeline
`timescale 1ns/1ps
`default_nettype none
module test_harvard_core_alu_pipeline;
  import hcap_pkg::*;
  logic                clk;
  logic                resetn;
  logic                mrst_n;
  logic                rc_mode;
  logic                start;
  logic                we;
  logic                done;
  logic [8:0]          waddr;
  logic [8:0]          pc;
  logic [INSTR_W-1:0]  wdata;
  logic [INSTR_W-1:0]  instr;
  logic [DATA_W-1:0]   w_reg;
  logic [DATA_W-1:0]   status;
  logic                xout;
  logic                core_rst;
  int                  bad_count;
  int                  n_tests;
  int                  cyc;
  int                  t0;

  hcap_core #(.PC_W(9)) dut_u (.i_clk_sys(clk), .i_resetn(resetn), .i_master_reset_n(mrst_n),
    .i_rc_mode(rc_mode), .i_pmem_we(we), .i_pmem_waddr(waddr), .i_pmem_wdata(wdata),
    .o_prog_addr(pc), .o_instr(instr), .o_w_reg(w_reg), .o_status(status),
    .o_xtal_out_pin(xout), .o_core_reset(core_rst));
  hcap_pmem_loader #(.PC_W(9)) loader_u (.i_clk_sys(clk), .i_start(start), .o_pmem_we(we),
    .o_pmem_waddr(waddr), .o_pmem_wdata(wdata), .o_done(done));

  // 100 MHz clock and free cycle count for timing measurements
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  // Bounded wait until the given word sits in the instruction register
  task automatic wait_word(input logic [INSTR_W-1:0] word);
    int k;
    for (k = 0; k < 200; k++)
    begin
      @(posedge clk);
      #1;
      if (instr === word)
        break;
    end
    check(16'(k < 200), 16'h0001);
  endtask : wait_word

  // Core held by the reset pin shows the documented reset state
  task automatic test_reset();
    repeat (4) @(posedge clk);
    #1;
    check(16'(core_rst), 16'h0001);
    check(16'(pc), 16'h01FF);
    check(16'(status), 16'(STATUS_RST));
    check(16'(w_reg), 16'h0000);
    @(posedge clk);
    mrst_n <= 1'b1;
  endtask : test_reset

  // Straight-line arithmetic then a taken jump with its flushed word
  task automatic test_program();
    int t1;
    wait_word(12'h0C0F);
    check(16'(pc), 16'h0001);
    t0 = cyc;
    wait_word(12'h0030);
    check(16'(cyc - t0), 16'h0004);
    check(16'(w_reg), 16'h000F);
    wait_word(12'h01D0);
    check(16'(w_reg), 16'h0001);
    wait_word(12'h0090);
    check(16'(w_reg), 16'h0010);
    check(16'(status), 16'h001A);
    wait_word(12'h0FFF);
    check(16'(w_reg), 16'h00FF);
    check(16'(status), 16'h001A);
    wait_word(12'h0A09);
    check(16'(w_reg), 16'h0000);
    check(16'(status), 16'h001E);
    t1 = cyc;
    wait_word(12'h0C55);
    check(16'(pc), 16'h0009);
    check(16'(cyc - t1), 16'h0004);
    wait_word(12'h0C77);
    check(16'(cyc - t1), 16'h0008);
    check(16'(w_reg), 16'h0000);
    wait_word(12'h0200);
    check(16'(w_reg), 16'h0011);
    wait_word(12'h0911);
    check(16'(w_reg), 16'h0077);
    check(16'(status), 16'h001A);
    // Call then return with literal: both flow changes cost one bubble
    t1 = cyc;
    wait_word(12'h08AB);
    check(16'(pc), 16'h0012);
    check(16'(cyc - t1), 16'h0008);
    repeat (8) @(posedge clk);
    #1;
    check(16'(instr), 16'h0A0F);
    check(16'(pc), 16'h0010);
    check(16'(w_reg), 16'h00AB);
  endtask : test_program

  // Cycle clock output: low outside RC mode, quarter rate inside it
  task automatic test_clock_out();
    int highs;
    int rises;
    logic prev;
    highs = 0;
    rises = 0;
    prev = xout;
    repeat (16)
    begin
      @(posedge clk);
      #1;
      highs += int'(xout === 1'b1);
    end
    check(16'(highs), 16'h0000);
    @(posedge clk);
    rc_mode <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    highs = 0;
    prev = xout;
    repeat (16)
    begin
      @(posedge clk);
      #1;
      highs += int'(xout === 1'b1);
      rises += int'(xout === 1'b1 && prev === 1'b0);
      prev = xout;
    end
    check(16'(highs), 16'h0008);
    check(16'(rises), 16'h0004);
  endtask : test_clock_out

  // Mid-run pin reset: core restarts from the vector, accumulator kept
  task automatic test_master_reset();
    int k;
    @(posedge clk);
    mrst_n <= 1'b0;
    for (k = 0; k < 20 && core_rst !== 1'b1; k++)
      @(posedge clk);
    repeat (2) @(posedge clk);
    #1;
    check(16'(core_rst), 16'h0001);
    check(16'(pc), 16'h01FF);
    check(16'(instr), 16'(INSTR_NOP));
    check(16'(status), 16'(STATUS_RST));
    check(16'(w_reg), 16'h00AB);
    @(posedge clk);
    mrst_n <= 1'b1;
    wait_word(12'h0C0F);
    check(16'(core_rst), 16'h0000);
    check(16'(pc), 16'h0001);
  endtask : test_master_reset

  // Main sequence: reset, load program, run scenarios
  initial
  begin
    resetn    = 1'b0;
    mrst_n    = 1'b0;
    rc_mode   = 1'b0;
    start     = 1'b0;
    bad_count = 0;
    n_tests   = 0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    start  <= 1'b1;
    wait (done === 1'b1);
    test_reset();
    test_program();
    test_clock_out();
    test_master_reset();
    summarize();
  end

  // Watchdog well beyond the few hundred cycles the scenarios need
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end
endmodule : test_harvard_core_alu_pipeline
`default_nettype wire
